//--- design/odc_decoder.sv
// serial command decoder with input and output code registers
// Notes on behaviour
// - frame is 16 bits msb first: 2 ignored, 3 address, 3 control, 8 data.
// - one bit shifted in per rising serial clock while select low; host sends 16.
// - power-on reset clears serial logic, input and output registers to zero.
// - code 000 does nothing on select rise; bits still pass through.
// - code 001 clears all input and output registers.
// - clear also leaves shutdown, enabling every channel again.
// - code 010 shuts down; each data bit enables its own channel output.
// - shutdown left only by reset, clear, load-all or load input-and-output.
// - code 011 with top address bit 0 picks falling-edge output, copies inputs.
// - code 011 with top address bit 1 picks rising-edge output, kept until mode 0.
// - mode 1 phase command also copies every input register to its output.
// - code 100 writes data to all outputs and leaves shutdown.
// - code 101 writes data to the addressed input register only.
// - code 110 writes addressed input and output registers, leaves shutdown.
// - code 111 copies every input register to its output register.
// - load pin low makes outputs follow input registers as a level.
// - serial output is last shift stage; lag 16.5 cycles mode 0, 16 mode 1.
// - serial output always driven and holds while select is high.
`default_nettype none
module odc_decoder
	import odc_pkg::*;
#(
	parameter int CHANNELS  = ODC_CHANNELS,
	parameter int CODE_BITS = ODC_CODE_BITS
) (
	// system clock and reset
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	// serial link, clocked by the host
	input  wire logic          link_sclk,
	input  wire logic          select_n,
	input  wire logic          serial_in,
	output logic               serial_out,
	// hardware load pin
	input  wire logic          load_outputs_n,
	// converter side
	output odc_codes_type      out_codes,
	output logic [7:0]         channel_enable,
	output logic               full_shutdown,
	output logic               phase_mode1,
	output logic               cmd_strobe
);

	// the logic is written for the documented eight 8-bit channels only
	if (CHANNELS != ODC_CHANNELS || CODE_BITS != ODC_CODE_BITS) begin : g_check
		$error("odc_decoder supports only eight channels of eight bits");
	end

	// link domain state
	logic [ODC_FRAME_BITS-1:0] shift_r;
	logic                      dout_fall_r;
	logic [1:0]                mode_sync_r;

	// system domain state
	logic [1:0]                sel_sync_r;
	logic                      sel_prev_r;
	logic [1:0]                load_sync_r;
	logic                      phase_mode1_r;
	logic [7:0]                enable_r;
	logic                      full_shutdown_r;
	logic                      cmd_strobe_r;
	odc_codes_type             in_regs_r;
	odc_codes_type             out_regs_r;
	odc_codes_type             in_regs_nxt;

	// decode helpers
	logic                      frame_go;
	odc_frame_type             frame;
	logic                      do_clear;
	logic                      do_load_all;
	logic                      do_in_write;
	logic                      do_in_out;
	logic                      do_transfer;
	logic                      do_shutdown;
	logic                      do_wake;
	logic                      do_phase;

	// ------------------------------------------------------------------
	// link domain
	// ------------------------------------------------------------------

	// edges with select high leave the word untouched
	always_ff @(posedge link_sclk or negedge rstn) begin
		if (!rstn) begin
			shift_r <= ODC_SHIFT_RST;
		end else if (!select_n) begin
			shift_r <= {shift_r[ODC_FRAME_BITS-2:0], serial_in};
		end
	end

	// mode 0 copy of last stage
	always_ff @(negedge link_sclk or negedge rstn) begin
		if (!rstn) begin
			dout_fall_r <= ODC_DOUT_RST;
		end else if (!select_n) begin
			dout_fall_r <= shift_r[ODC_FRAME_BITS-1];
		end
	end

	// phase setting crosses into the link domain as a level;
	// it settles after two serial clocks of the next frame
	always_ff @(posedge link_sclk or negedge rstn) begin
		if (!rstn) begin
			mode_sync_r <= ODC_SYNC_RST;
		end else begin
			mode_sync_r <= {mode_sync_r[0], phase_mode1_r};
		end
	end

	// select the edge the output changes on
	always_comb begin
		serial_out = mode_sync_r[1] ? shift_r[ODC_FRAME_BITS-1] : dout_fall_r;
	end

	// ------------------------------------------------------------------
	// crossings into the system domain
	// ------------------------------------------------------------------

	// select pin into sys_clk; idle level is high so the chain resets high
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sel_sync_r <= ODC_SYNC_HIGH;
			sel_prev_r <= 1'b1;
		end else begin
			sel_sync_r <= {sel_sync_r[0], select_n};
			sel_prev_r <= sel_sync_r[1];
		end
	end

	// load pin is asynchronous, two flops before use
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			load_sync_r <= ODC_SYNC_HIGH;
		end else begin
			load_sync_r <= {load_sync_r[0], load_outputs_n};
		end
	end

	// one command per select rise
	// the shift word is static once select is high, so it is read directly
	assign frame_go = sel_sync_r[1] & ~sel_prev_r;
	// split the frame into its fields
	assign frame    = odc_frame_type'(shift_r);

	// ------------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------------

	// no-op and pass-through match no strobe below
	always_comb begin
		do_clear    = 1'b0;
		do_load_all = 1'b0;
		do_in_write = 1'b0;
		do_in_out   = 1'b0;
		do_transfer = 1'b0;
		do_shutdown = 1'b0;
		do_phase    = 1'b0;
		if (frame_go) begin
			unique case (frame.ctrl_code)
				ODC_CMD_NOP: begin
					do_clear = 1'b0;
				end
				ODC_CMD_CLEAR: begin
					do_clear = 1'b1;
				end
				ODC_CMD_SHUTDOWN: begin
					do_shutdown = 1'b1;
				end
				ODC_CMD_PHASE: begin
					do_phase    = 1'b1;
					do_transfer = 1'b1;
				end
				ODC_CMD_LOAD_ALL: begin
					do_load_all = 1'b1;
				end
				ODC_CMD_LOAD_IN: begin
					do_in_write = 1'b1;
				end
				ODC_CMD_LOAD_IN_OUT: begin
					do_in_write = 1'b1;
					do_in_out   = 1'b1;
				end
				ODC_CMD_SW_LOAD: begin
					do_transfer = 1'b1;
				end
			endcase
		end
	end

	// only these three commands leave shutdown
	assign do_wake = do_clear | do_load_all | do_in_out;

	// ------------------------------------------------------------------
	// command state
	// ------------------------------------------------------------------

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			enable_r <= ODC_ENABLE_RST;
		end else if (do_wake) begin
			enable_r <= ODC_ENABLE_ALL;
		end else if (do_shutdown) begin
			enable_r <= frame.payload_bits;
		end
	end

	// full shutdown flag kept beside the enables so the port is a flop
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			full_shutdown_r <= ~|ODC_ENABLE_RST;
		end else if (do_wake) begin
			full_shutdown_r <= 1'b0;
		end else if (do_shutdown) begin
			full_shutdown_r <= ~|frame.payload_bits;
		end
	end

	// phase latched until reset or a mode 0 command
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			phase_mode1_r <= ODC_PHASE_RST;
		end else if (do_phase) begin
			phase_mode1_r <= frame.channel_address_field[ODC_ADDR_BITS-1];
		end
	end

	// a pulse per decoded frame, handy for whoever watches the block
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_strobe_r <= 1'b0;
		end else begin
			cmd_strobe_r <= frame_go;
		end
	end

	// ------------------------------------------------------------------
	// per-channel input and output registers
	// ------------------------------------------------------------------

	for (genvar ch = 0; ch < ODC_CHANNELS; ch++) begin : g_chan
		logic addr_hit;

		assign addr_hit = (frame.channel_address_field == ODC_ADDR_BITS'(ch));

		always_comb begin
			if (do_clear) begin
				in_regs_nxt[ch] = ODC_CODE_RST;
			end else if (do_in_write && addr_hit) begin
				in_regs_nxt[ch] = frame.payload_bits;
			end else begin
				in_regs_nxt[ch] = in_regs_r[ch];
			end
		end

		// input register reset to code zero
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				in_regs_r[ch] <= ODC_CODE_RST;
			end else begin
				in_regs_r[ch] <= in_regs_nxt[ch];
			end
		end

		// an explicit command write wins for its own cycle; while the load
		// pin stays low the output returns to tracking the input next cycle
		always_ff @(posedge sys_clk or negedge rstn) begin
			if (!rstn) begin
				out_regs_r[ch] <= ODC_CODE_RST;
			end else if (do_clear) begin
				out_regs_r[ch] <= ODC_CODE_RST;
			end else if (do_load_all) begin
				out_regs_r[ch] <= frame.payload_bits;
			end else if (do_in_out && addr_hit) begin
				out_regs_r[ch] <= frame.payload_bits;
			end else if (do_transfer) begin
				out_regs_r[ch] <= in_regs_r[ch];
			end else if (!load_sync_r[1]) begin
				out_regs_r[ch] <= in_regs_nxt[ch];
			end
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------

	// all registered; serial_out alone is a mux, since one flop cannot serve both edges
	assign out_codes      = out_regs_r;
	assign channel_enable = enable_r;
	assign full_shutdown  = full_shutdown_r;
	assign phase_mode1    = phase_mode1_r;
	assign cmd_strobe     = cmd_strobe_r;

endmodule : odc_decoder
`default_nettype wire

//--- design/odc_pkg.sv
// package for the octal converter serial command decoder
`default_nettype none
package odc_pkg;

	// frame geometry
	localparam int ODC_FRAME_BITS = 16;
	localparam int ODC_CHANNELS   = 8;
	localparam int ODC_CODE_BITS  = 8;
	localparam int ODC_ADDR_BITS  = 3;

	// field positions inside the 16-bit frame, msb first on the wire
	localparam int ODC_PAYLOAD_LSB = 0;
	localparam int ODC_CTRL_LSB    = 8;
	localparam int ODC_ADDR_LSB    = 11;
	localparam int ODC_IGNORED_LSB = 14;

	// values after reset
	localparam logic [15:0] ODC_SHIFT_RST  = 16'h0000;
	localparam logic [7:0]  ODC_CODE_RST   = 8'h00;
	localparam logic [7:0]  ODC_ENABLE_RST = 8'hff;
	localparam logic [7:0]  ODC_ENABLE_ALL = 8'hff;
	localparam logic        ODC_PHASE_RST  = 1'b0;
	localparam logic        ODC_DOUT_RST   = 1'b0;
	localparam logic [1:0]  ODC_SYNC_RST   = 2'h0;
	localparam logic [1:0]  ODC_SYNC_HIGH  = 2'h3;

	// control codes carried in ctrl_bit2..ctrl_bit0
	typedef enum logic [2:0] {
		ODC_CMD_NOP        = 3'h0,
		ODC_CMD_CLEAR      = 3'h1,
		ODC_CMD_SHUTDOWN   = 3'h2,
		ODC_CMD_PHASE      = 3'h3,
		ODC_CMD_LOAD_ALL   = 3'h4,
		ODC_CMD_LOAD_IN    = 3'h5,
		ODC_CMD_LOAD_IN_OUT = 3'h6,
		ODC_CMD_SW_LOAD    = 3'h7
	} odc_cmd_type;

	// one received frame, msb first
	typedef struct packed {
		logic [1:0]  ignored_bits;
		logic [2:0]  channel_address_field;
		odc_cmd_type ctrl_code;
		logic [7:0]  payload_bits;
	} odc_frame_type;

	// all eight output codes side by side, channel 0 in the low byte
	typedef logic [ODC_CHANNELS-1:0][ODC_CODE_BITS-1:0] odc_codes_type;

endpackage : odc_pkg
`default_nettype wire

//--- testbench/odc_decoder_asserts.sv
// port property checker for the serial command decoder
`default_nettype none
module odc_decoder_asserts
	import odc_pkg::*;
(
	// clock and reset
	input wire logic          sys_clk,
	input wire logic          rstn,
	// link and load pin
	input wire logic          select_n,
	input wire logic          load_outputs_n,
	input wire logic          serial_out,
	// converter side
	input wire odc_codes_type out_codes,
	input wire logic [7:0]    channel_enable,
	input wire logic          full_shutdown,
	input wire logic          phase_mode1,
	input wire logic          cmd_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// power-on values seen at release
	a_reset_values: assert property ($rose(rstn) |-> out_codes == '0 &&
		!phase_mode1 && channel_enable == 8'hff) else $error("bad values after reset");
	a_shut_flag: assert property (full_shutdown == (channel_enable == 8'h00))
		else $error("shutdown flag disagrees with enables");
	a_strobe_single: assert property (cmd_strobe |=> !cmd_strobe)
		else $error("strobe longer than one cycle");
	a_strobe_after_sel: assert property ($rose(cmd_strobe) |-> $past(select_n, 3))
		else $error("strobe without select high");
	a_enable_cause: assert property ($changed(channel_enable) |-> cmd_strobe)
		else $error("enables changed without a command");
	a_phase_cause: assert property ($changed(phase_mode1) |-> cmd_strobe)
		else $error("phase changed without a command");
	// with the load pin high only a command may move outputs
	a_codes_cause: assert property ($changed(out_codes) && load_outputs_n &&
		$past(load_outputs_n, 4) |-> cmd_strobe) else $error("codes moved without a command");
	a_out_hold: assert property (select_n && $past(select_n, 2) |-> $stable(serial_out))
		else $error("serial output moved while deselected");
	cover property (cmd_strobe && phase_mode1);
	cover property (full_shutdown);
	cover property (!load_outputs_n && $changed(out_codes));
endmodule // odc_decoder_asserts
`default_nettype wire

//--- testbench/odc_decoder_test.sv
// self-checking bench for the serial command decoder
`default_nettype none
module odc_decoder_test
	import odc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rstn, load_outputs_n, go, link_sclk, select_n, serial_in;
	logic serial_out, busy, full_shutdown, phase_mode1, cmd_strobe, ph_e, skip_rx;
	logic [7:0] channel_enable, en_e;
	logic [15:0] word, rx, rx_late, last;
	odc_codes_type out_codes, in_e, out_e;
	int num_errors, checks;
	odc_decoder u_odc_decoder (.sys_clk(sys_clk), .rstn(rstn), .link_sclk(link_sclk),
		.select_n(select_n), .serial_in(serial_in), .serial_out(serial_out),
		.load_outputs_n(load_outputs_n), .out_codes(out_codes),
		.channel_enable(channel_enable), .full_shutdown(full_shutdown),
		.phase_mode1(phase_mode1), .cmd_strobe(cmd_strobe));
	odc_host_model u_odc_host_model (.go(go), .word(word), .serial_out(serial_out),
		.link_sclk(link_sclk), .select_n(select_n), .serial_in(serial_in),
		.busy(busy), .rx(rx), .rx_late(rx_late));
	// 40 MHz system clock
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [63:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("checks=%0d num_errors=%0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// one frame, then expected state from the command table
	task automatic send(input logic [15:0] w);
		logic [2:0]  a;
		logic [7:0]  d;
		logic [15:0] lat;
		logic [7:0]  seen;
		a = w[13:11];
		d = w[7:0];
		// just after a rising edge, mode 1 already shows the next bit
		lat = ph_e ? {last[14:0], w[15]} : last;
		seen = '0;
		word <= w;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		for (int n = 0; n < 60 && busy; n++) begin
			@(posedge sys_clk);
			seen = seen + 8'(cmd_strobe);
		end
		chk(busy, 1'b0);
		chk(seen, 8'h01);
		case (w[10:8])
			3'h1: begin in_e = '0; out_e = '0; en_e = 8'hff; end
			3'h2: en_e = d;
			3'h3: begin ph_e = a[2]; out_e = in_e; end
			3'h4: begin out_e = {8{d}}; en_e = 8'hff; end
			3'h5: in_e[a] = d;
			3'h6: begin in_e[a] = d; out_e[a] = d; en_e = 8'hff; end
			3'h7: out_e = in_e;
			default: ;
		endcase
		// level load: outputs end up tracking inputs
		if (!load_outputs_n) out_e = in_e;
		chk(out_codes, out_e);
		chk(channel_enable, en_e);
		chk(full_shutdown, en_e == 8'h00);
		chk(phase_mode1, ph_e);
		if (!skip_rx) chk(rx, last);
		if (!skip_rx) chk(rx_late, lat);
		// phase switch settles during the following frame
		skip_rx = (w[10:8] == 3'h3);
		last = w;
	endtask
	task automatic t_reset();
		chk(out_codes, '0);
		chk({channel_enable, phase_mode1, full_shutdown, serial_out}, 11'h7f8);
	endtask
	// seven input-only writes, one input-and-output write, two transfers, then another input-and-output write
	task automatic t_inputs();
		for (int i = 0; i < 7; i++) send({2'b00, i[2:0], 3'h5, 8'h10 + 8'(i)});
		send(16'h3e17);
		send(16'h3fff);
		send(16'h0700);
		send(16'h1ea5);
	endtask
	task automatic t_shutdown();
		logic [15:0] s[] = '{16'h025a, 16'h0d77, 16'h0700, 16'h0200, 16'h0433,
			16'h0200, 16'h0100, 16'h020f, 16'h169c};
		foreach (s[i]) send(s[i]);
	endtask
	task automatic t_phase();
		logic [15:0] s[] = '{16'hc544, 16'h2300, 16'h00ab, 16'h00cd, 16'h0555,
			16'h0300, 16'h00ee, 16'h0011};
		foreach (s[i]) send(s[i]);
	endtask
	task automatic t_load();
		load_outputs_n <= 1'b0;
		send(16'h0000);
		send(16'h3de1);
		send(16'h0444);
		load_outputs_n <= 1'b1;
		send(16'h0000);
		send(16'h0599);
	endtask
	// reset in mid-run must clear live registers and the phase
	task automatic t_rerun_reset();
		rstn <= 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		t_reset();
		{in_e, out_e, ph_e, skip_rx, last} = '0;
		en_e = 8'hff;
		@(posedge sys_clk);
		send(16'h0700);
	endtask
	// main sequence
	initial begin
		{go, word, num_errors, checks, in_e, out_e, ph_e, skip_rx, last} = '0;
		rstn = 1'b1;
		load_outputs_n = 1'b1;
		en_e = 8'hff;
		// a real falling edge so every asynchronous reset branch runs
		#2 rstn = 1'b0;
		repeat (4) @(posedge sys_clk);
		rstn <= 1'b1;
		@(negedge sys_clk);
		t_reset();
		@(posedge sys_clk);
		t_inputs();
		t_shutdown();
		t_phase();
		t_load();
		t_rerun_reset();
		summarize();
	end
	// watchdog well beyond the expected run
	initial begin
		#100us;
		num_errors++;
		summarize();
	end
endmodule // odc_decoder_test
bind odc_decoder odc_decoder_asserts u_odc_decoder_asserts (.sys_clk(sys_clk), .rstn(rstn),
	.select_n(select_n), .load_outputs_n(load_outputs_n), .serial_out(serial_out),
	.out_codes(out_codes), .channel_enable(channel_enable),
	.full_shutdown(full_shutdown), .phase_mode1(phase_mode1), .cmd_strobe(cmd_strobe));
`default_nettype wire

//--- testbench/odc_host_model.sv
// behavioural serial host: sends one frame per go pulse
`default_nettype none
module odc_host_model (
	// request from the bench
	input wire logic        go,
	input wire logic [15:0] word,
	// link pins
	input wire logic        serial_out,
	output logic            link_sclk,
	output logic            select_n,
	output logic            serial_in,
	// status and captured chain output
	output logic            busy,
	output logic [15:0]     rx,
	output logic [15:0]     rx_late
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{link_sclk, serial_in, busy, rx, rx_late} = '0;
		select_n = 1'b1;
	end
	// whole 16-bit frame msb first, clock idles low
	always @(posedge go) begin
		busy = 1'b1;
		select_n = 1'b0;
		#41;
		for (int i = 15; i >= 0; i--) begin
			serial_in = word[i];
			#3 rx = {rx[14:0], serial_out};
			link_sclk = 1'b1;
			// a second look just after the rising edge tells the phases apart
			#1 rx_late = {rx_late[14:0], serial_out};
			#2 link_sclk = 1'b0;
		end
		#2 select_n = 1'b1;
		// released data line must not keep its last value
		serial_in = ~serial_in;
		#200 busy = 1'b0;
	end
endmodule // odc_host_model
`default_nettype wire
